/* seami_addr_match.sv */
// Address comparator: masked, dual and range variants on a 7- or 8-bit address.
// Assumes configuration is held stable while an address is presented.
`timescale 1ns/1ps
`include "seami_map.svh"

module seami_addr_match
  import seami_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Configuration and request
  input wire seami_match_cfg_t cfg,
  input wire seami_addr_t addr_in,
  // Result
  output logic match_ff,
  output logic miss_ff
);

  // Clip all three operands to the active width so unused top bit never interferes
  function automatic logic [7:0] clip(input logic [7:0] v, input logic wide);
    clip = wide ? v : {1'b0, v[6:0]};
  endfunction

  wire [7:0] a = clip(addr_in.addr, cfg.wide);
  wire [7:0] val = clip(cfg.match_val, cfg.wide);
  wire [7:0] msk = clip(cfg.match_mask_or_bound, cfg.wide);

  wire hit_mask = ((a ^ val) & ~msk) == 8'h00;
  wire hit_dual = (a == val) || (a == msk);
  wire hit_range = (a >= msk) && (a <= val);

  logic hit;
  always_comb begin
    case (cfg.variant)
      2'd0: hit = hit_mask;
      2'd1: hit = hit_dual;
      2'd2: hit = hit_range;
      default: hit = 1'b0;
    endcase
  end

  wire nxt_match = addr_in.valid & hit;
  wire nxt_miss = addr_in.valid & ~hit;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      match_ff <= 1'b0;
      miss_ff <= 1'b0;
    end else begin
      match_ff <= nxt_match;
      miss_ff <= nxt_miss;
    end
  end

endmodule

/* seami_addr_src.sv */
// Serial-side master model handing address packets to the engine.
// Assumes callers start just after a rising edge of sys_clk.
`timescale 1ns/1ps
module seami_addr_src (
  // Clock
  input wire logic sys_clk,
  // Address packet
  output logic addr_valid,
  output logic [7:0] addr_data
);
  logic [7:0] last = 8'h00;
  initial begin
    addr_valid = 1'b0;
    addr_data = 8'hff;
  end
  // Valid stays up across calls so packets can run back to back
  task automatic send(input logic [7:0] a);
    last = a;
    addr_valid <= 1'b1;
    addr_data <= a;
    @(posedge sys_clk);
  endtask
  // Released data is inverted so a stale byte never passes for a packet
  task automatic idle(input int n);
    addr_valid <= 1'b0;
    addr_data <= ~last;
    repeat (n) @(posedge sys_clk);
  endtask
endmodule

/* seami_core.sv */
// Serial engine shared logic: APB registers, address match and interrupt flags.
// Assumes a single 100 MHz clock; address packets and mode events arrive synchronous to it.
//
// Overview of operation
// - Masked mode compares address with match value, skipping masked bit positions.
// - Mask all zeros accepts one address; mask all ones accepts every address.
// - Dual mode matches either the match value or the mask field value.
// - Range mode matches from mask field (low) to match value (high), inclusive.
// - Comparison uses seven or eight address bits, selected by the control wide bit.
// - Each interrupt source has its own flag, set when its condition occurs while the engine is enabled.
// - Ones to enable-set enable, ones to enable-clear disable; zeros do nothing.
// - Interrupt request is high while any flag and its enable are set.
// - Request holds until flag cleared, enable removed, or engine reset.
// - Engine keeps working in low power while its serial clock runs.
// - Interrupt request can serve as a wake-up source.
// - Engine enable crossing into the core side is synchronised before use; other control fields are used directly.
`timescale 1ns/1ps
`include "seami_map.svh"

module seami_core
  import seami_pkg::*;
#(
  parameter int NUM_FLAGS = `SEAMI_NUM_FLAGS
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Address packets from the serial side
  input wire logic addr_valid,
  input wire logic [7:0] addr_data,
  // Mode-specific event sources
  input wire logic [NUM_FLAGS-1:0] src_event,
  // Serial side status
  output logic engine_enable,
  output logic match_strobe,
  // Interrupt and wake-up
  output logic irq,
  output logic wake_req
);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire sel_ctrl = paddr == `SEAMI_OFF_CTRL;
  wire sel_match = paddr == `SEAMI_OFF_MATCH;
  wire sel_flag = paddr == `SEAMI_OFF_FLAG;
  wire sel_enset = paddr == `SEAMI_OFF_ENSET;
  wire sel_enclr = paddr == `SEAMI_OFF_ENCLR;
  wire sel_status = paddr == `SEAMI_OFF_STATUS;
  wire sel_addr = paddr == `SEAMI_OFF_ADDR;
  wire mapped = sel_ctrl | sel_match | sel_flag | sel_enset | sel_enclr | sel_status | sel_addr;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // ----------------------------------------------------------------
  // Control and match registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_ff;
  logic [31:0] match_ff;
  logic swrst_ff;
  wire swrst_wr = wr & sel_ctrl & pwdata[`SEAMI_CTRL_SWRST_BIT];

  // Soft reset returns control, match, flag and enable registers to initial values (not last address), engine disabled
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= `SEAMI_CTRL_RST;
      match_ff <= `SEAMI_MATCH_RST;
      swrst_ff <= 1'b0;
    end else begin
      swrst_ff <= swrst_wr;
      if (swrst_wr) begin
        ctrl_ff <= `SEAMI_CTRL_RST;
        match_ff <= `SEAMI_MATCH_RST;
      end else begin
        if (wr & sel_ctrl)
          ctrl_ff <= {28'h000_0000, pwdata[3:0]};
        if (wr & sel_match)
          match_ff <= {8'h00, pwdata[23:16], 8'h00, pwdata[7:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable crossing into the core side
  // ----------------------------------------------------------------
  // Inputs are synchronous here, but the enable still passes two stages so
  // a later split into a separate core clock keeps the same timing.
  logic [`SEAMI_SYNC_STAGES-1:0] en_sync_ff;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      en_sync_ff <= '0;
    else
      en_sync_ff <= {en_sync_ff[0], ctrl_ff[`SEAMI_CTRL_EN_BIT]};
  end
  wire core_en = en_sync_ff[`SEAMI_SYNC_STAGES-1];
  assign engine_enable = core_en;
  wire sync_busy = core_en != ctrl_ff[`SEAMI_CTRL_EN_BIT];

  // ----------------------------------------------------------------
  // Address match
  // ----------------------------------------------------------------
  seami_match_cfg_t cfg;
  seami_addr_t pkt;
  logic hit_ff;
  logic miss_ff;
  logic [7:0] last_addr_ff;

  // No gating by low-power state: the engine runs whenever its clock runs
  assign cfg.wide = ctrl_ff[`SEAMI_CTRL_WIDE_BIT];
  assign cfg.variant = ctrl_ff[`SEAMI_CTRL_VAR_LSB +: 2];
  assign cfg.match_val = match_ff[`SEAMI_MATCH_VAL_LSB +: 8];
  assign cfg.match_mask_or_bound = match_ff[`SEAMI_MATCH_MSK_LSB +: 8];
  assign pkt.valid = addr_valid & core_en;
  assign pkt.addr = addr_data;

  seami_addr_match u_match (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .cfg(cfg),
    .addr_in(pkt),
    .match_ff(hit_ff),
    .miss_ff(miss_ff)
  );

  assign match_strobe = hit_ff;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      last_addr_ff <= 8'h00;
    else if (pkt.valid)
      last_addr_ff <= addr_data;
  end

  // ----------------------------------------------------------------
  // Interrupt flags and enables
  // ----------------------------------------------------------------
  logic [NUM_FLAGS-1:0] irq_flag_reg_ff;
  logic [NUM_FLAGS-1:0] irq_enable_ff;

  // Match outcomes feed the two lowest sources alongside external ones
  logic [NUM_FLAGS-1:0] set_vec;
  always_comb begin
    set_vec = src_event & {NUM_FLAGS{core_en}};
    set_vec[`SEAMI_FLAG_MATCH] = set_vec[`SEAMI_FLAG_MATCH] | hit_ff;
    set_vec[`SEAMI_FLAG_NOMATCH] = set_vec[`SEAMI_FLAG_NOMATCH] | miss_ff;
  end

  wire [NUM_FLAGS-1:0] flag_clr = (wr & sel_flag) ? pwdata[NUM_FLAGS-1:0] : '0;
  wire [NUM_FLAGS-1:0] en_set = (wr & sel_enset) ? pwdata[NUM_FLAGS-1:0] : '0;
  wire [NUM_FLAGS-1:0] en_clr = (wr & sel_enclr) ? pwdata[NUM_FLAGS-1:0] : '0;

  // A new event beats a clear in the same cycle so it is never lost
  wire [NUM_FLAGS-1:0] nxt_flag = (irq_flag_reg_ff & ~flag_clr) | set_vec;
  wire [NUM_FLAGS-1:0] nxt_en = (irq_enable_ff | en_set) & ~en_clr;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_flag_reg_ff <= '0;
      irq_enable_ff <= '0;
    end else if (swrst_wr) begin
      irq_flag_reg_ff <= '0;
      irq_enable_ff <= '0;
    end else begin
      irq_flag_reg_ff <= nxt_flag;
      irq_enable_ff <= nxt_en;
    end
  end

  // Level output, drops as soon as flag or enable goes away
  assign irq = |(irq_flag_reg_ff & irq_enable_ff);
  assign wake_req = irq;

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  wire [31:0] flag_word = {{(32-NUM_FLAGS){1'b0}}, irq_flag_reg_ff};
  wire [31:0] en_word = {{(32-NUM_FLAGS){1'b0}}, irq_enable_ff};
  wire [31:0] status_word = {29'h0000_0000, sync_busy, core_en, swrst_ff};
  wire [31:0] rd_mux =
    sel_ctrl ? ctrl_ff :
    sel_match ? match_ff :
    sel_flag ? flag_word :
    (sel_enset | sel_enclr) ? en_word :
    sel_status ? status_word :
    sel_addr ? {24'h00_0000, last_addr_ff} : 32'h0000_0000;

  // Read data registered during setup so it is stable in the access phase
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata <= rd_mux;
  end

endmodule

/* seami_core_sva.sv */
// Port-level checker for the serial engine match and interrupt block.
// Assumes it is bound onto seami_core, which runs on one clock.
`timescale 1ns/1ps
module seami_core_sva #(
  parameter int NUM_FLAGS = 4
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Serial side and results
  input wire logic addr_valid,
  input wire logic [NUM_FLAGS-1:0] src_event,
  input wire logic engine_enable,
  input wire logic match_strobe,
  input wire logic irq,
  input wire logic wake_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire wr = psel && penable && pwrite;
  wire ctl_wr = wr && paddr == 12'h000 && !pwdata[4];
  // ----
  // Properties
  // ----
  strobe_cause_a: assert property (match_strobe |-> $past(addr_valid && engine_enable))
    else $error("match strobe without accepted address");
  off_ignored_a: assert property (addr_valid && !engine_enable |=> !match_strobe)
    else $error("address taken while engine off");
  wake_same_a: assert property (wake_req == irq)
    else $error("wake request differs from irq");
  // An address reaches a flag one cycle after its strobe, so its cause lies two samples back
  irq_rise_a: assert property ($rose(irq) |-> $past(addr_valid, 2) || $past((|src_event) || wr))
    else $error("irq rose without a cause");
  irq_drop_a: assert property ($fell(irq) |-> $past(wr))
    else $error("irq fell without a register write");
  zero_clear_a: assert property (wr && paddr == 12'h010 && pwdata == 32'h0000_0000 |=> !$fell(irq))
    else $error("zero enable-clear write dropped irq");
  en_rise_a: assert property (ctl_wr && pwdata[0] && !engine_enable |-> ##[1:3] engine_enable)
    else $error("engine enable not seen in time");
  en_fall_a: assert property (ctl_wr && !pwdata[0] && engine_enable |-> ##[1:3] !engine_enable)
    else $error("engine disable not seen in time");
  match_c: cover property (match_strobe);
  irq_up_c: cover property ($rose(irq));
  irq_down_c: cover property ($fell(irq));
endmodule
bind seami_core seami_core_sva #(.NUM_FLAGS(NUM_FLAGS)) u_sva (.sys_clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .addr_valid, .src_event, .engine_enable, .match_strobe, .irq, .wake_req);

/* seami_core_tb_top.sv */
// Self-checking bench: match variants, flags, enables and soft reset.
// Assumes seami_addr_src as serial master and the bound checker.
`timescale 1ns/1ps
module seami_core_tb_top;
  logic sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, av_d = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] src_event = 4'h0;
  wire [31:0] prdata;
  wire pready, pslverr, addr_valid, engine_enable, match_strobe, irq, wake_req;
  wire [7:0] addr_data;
  logic [31:0] rq[$], mq[$];
  integer seed = 32'hfa80;
  int failures = 0, comparisons = 0;
  logic [18:0] tc[6] = '{{2'h0, 1'b1, 8'ha5, 8'h00}, {2'h0, 1'b1, 8'ha5, 8'hff}, {2'h0, 1'b0, 8'h35, 8'h0f},
    {2'h1, 1'b1, 8'h12, 8'hc4}, {2'h2, 1'b1, 8'h80, 8'h20}, {2'h2, 1'b0, 8'h50, 8'h10}};
  logic [13:0] st[6] = '{{12'h00c, 2'b11}, {12'h00c, 2'b01}, {12'h010, 2'b01}, {12'h010, 2'b10},
    {12'h00c, 2'b11}, {12'h008, 2'b10}};
  always #5 sys_clk = ~sys_clk;
  seami_core #(.NUM_FLAGS(4)) dut (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .addr_valid, .addr_data, .src_event, .engine_enable, .match_strobe, .irq, .wake_req);
  seami_addr_src u_src (.sys_clk, .addr_valid, .addr_data);
  // ----
  // Shared tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Trailing idle edge keeps psel from being driven twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  function automatic logic [31:0] em(input logic [1:0] v, input logic wd, input logic [7:0] mv,
    input logic [7:0] mk, input logic [7:0] a);
    logic [7:0] m;
    m = wd ? 8'hff : 8'h7f;
    mv &= m;
    mk &= m;
    a &= m;
    case (v)
      2'h0: em = ((a ^ mv) & ~mk) == 8'h00;
      2'h1: em = (a == mv) || (a == mk);
      default: em = (a >= mk) && (a <= mv);
    endcase
  endfunction
  // ----
  // Result watcher
  // ----
  always @(posedge sys_clk) begin
    if (psel && penable && !pwrite && pready) chk("prdata", prdata, rq.pop_front());
    if (av_d) chk("match_strobe", {31'h0, match_strobe}, mq.pop_front());
    if (psel && penable) chk("pslverr", {31'h0, pslverr}, {31'h0, (paddr > 12'h018) || (paddr[1:0] != 2'b00)});
    av_d <= addr_valid;
  end
  initial begin
    #100_000;
    failures++;
    final_report;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    logic [18:0] c;
    logic [7:0] a[6];
    logic [3:0] ev;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    foreach (tc[i]) begin
      c = tc[i];
      apb(1'b1, 12'h004, {8'h00, c[7:0], 8'h00, c[15:8]});
      apb(1'b1, 12'h000, {27'h0, 1'b0, c[16], c[18:17], 1'b1});
      repeat (4) @(posedge sys_clk);
      chk("engine_enable", {31'h0, engine_enable}, 32'h0000_0001);
      a = '{c[15:8], c[7:0], c[15:8] + 8'h01, c[7:0] - 8'h01, c[15:8] ^ 8'h80, 8'($random(seed))};
      foreach (a[j]) begin
        mq.push_back(em(c[18:17], c[16], c[15:8], c[7:0], a[j]));
        u_src.send(a[j]);
        if ($random(seed) & 1) u_src.idle(1);
      end
      u_src.idle(2);
      $display("test match case %0d done", i);
    end
    rd(12'h014, 32'h0000_0002);
    rd(12'h018, {24'h00_0000, a[5]});
    rd(12'h008, 32'h0000_0003);
    apb(1'b1, 12'h008, 32'h0000_000f);
    rd(12'h008, 32'h0000_0000);
    rd(12'h00c, 32'h0000_0000);
    ev = 4'($random(seed)) | 4'h4;
    src_event <= ev;
    @(posedge sys_clk);
    src_event <= 4'h0;
    rd(12'h008, {28'h000_0000, ev});
    foreach (st[k]) begin
      apb(1'b1, st[k][13:2], {29'h0, st[k][1], 2'b00});
      chk("irq", {31'h0, irq}, {31'h0, st[k][0]});
      chk("wake_req", {31'h0, wake_req}, {31'h0, st[k][0]});
    end
    rd(12'h00c, 32'h0000_0004);
    $display("test interrupt enables done");
    src_event <= 4'h4;
    @(posedge sys_clk);
    src_event <= 4'h0;
    @(posedge sys_clk);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0010);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    rd(12'h000, 32'h0000_0000);
    rd(12'h00c, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    chk("engine_enable", {31'h0, engine_enable}, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0000);
    repeat (3) @(posedge sys_clk);
    chk("engine_enable", {31'h0, engine_enable}, 32'h0000_0000);
    // 8'h80 clips to the stored narrow value, so only the disable keeps it quiet
    mq.push_back(32'h0000_0000);
    u_src.send(8'h80);
    u_src.idle(2);
    rd(12'h01c, 32'h0000_0000);
    $display("test soft reset done");
    final_report;
  end
endmodule

/* seami_map.svh */
// Offsets, field positions, reset values and timing counts for the serial engine match/irq block.
// Assumes inclusion by its bare name from design files only.
`ifndef SEAMI_MAP_SVH
`define SEAMI_MAP_SVH

// Register byte addresses on APB
`define SEAMI_OFF_CTRL        12'h000
`define SEAMI_OFF_MATCH       12'h004
`define SEAMI_OFF_FLAG        12'h008
`define SEAMI_OFF_ENSET       12'h00C
`define SEAMI_OFF_ENCLR       12'h010
`define SEAMI_OFF_STATUS      12'h014
`define SEAMI_OFF_ADDR        12'h018

// Control fields
`define SEAMI_CTRL_EN_BIT     0
`define SEAMI_CTRL_VAR_LSB    1
`define SEAMI_CTRL_WIDE_BIT   3
`define SEAMI_CTRL_SWRST_BIT  4

// Match register fields
`define SEAMI_MATCH_VAL_LSB   0
`define SEAMI_MATCH_MSK_LSB   16

// Flag bit positions
`define SEAMI_FLAG_MATCH      0
`define SEAMI_FLAG_NOMATCH    1
`define SEAMI_NUM_FLAGS       4

// Reset values
`define SEAMI_CTRL_RST        32'h0000_0000
`define SEAMI_MATCH_RST       32'h0000_0000

// Address width choices
`define SEAMI_ADDR_NARROW     7
`define SEAMI_ADDR_WIDE       8

// Synchroniser depth into the core domain
`define SEAMI_SYNC_STAGES     2

`endif

/* seami_pkg.sv */
// Types shared by the serial engine match/irq block.
// Assumes seami_map.svh is compiled alongside.
package seami_pkg;

  typedef enum logic [2:0] {
    SEAMI_VAR_MASK  = 3'b001,
    SEAMI_VAR_DUAL  = 3'b010,
    SEAMI_VAR_RANGE = 3'b100
  } seami_var_t;

  typedef struct packed {
    logic       wide;
    logic [1:0] variant;
    logic [7:0] match_val;
    logic [7:0] match_mask_or_bound;
  } seami_match_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
  } seami_addr_t;

endpackage
